// [rtl/tap_pkg.sv]
/*
  Shared constants and types of the boundary-scan test port: instruction codes,
  scan register sizes, controller states and the register map of the bus slave.
  Assumes nothing of its surroundings.
*/
package tap_pkg;
  // scan register sizes
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 109;
  localparam int OE_CELL = 108;

  // instruction codes
  localparam logic [IR_W-1:0] INS_EXT_TEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDENT = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPT_PAT = 2'h1;

  // identification code: value is arbitrary, bit 0 marks an id register
  localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0A5C_3001;

  // boundary cells after reset: output-enable cell high, the rest low
  localparam logic [BSR_W-1:0] BSR_UPD_RST = {1'b1, {(BSR_W-1){1'b0}}};

  // consecutive high tms edges that always reach test-logic-reset
  localparam logic [2:0] TMS_RST_EDGES = 3'h5;

  // register map of the bus slave, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IDREAD = 4'h8;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_IR_LSB = 4;
  localparam int ST_OE_BIT = 7;
  localparam int ST_HIGHZ_BIT = 8;
  localparam int ST_EXT_BIT = 9;
  localparam int CTRL_RST_BIT = 0;

  // controller states
  typedef enum logic [3:0] {
    ST_EX2_DR = 4'h0, ST_EX1_DR = 4'h1, ST_SH_DR = 4'h2, ST_PA_DR = 4'h3,
    ST_SEL_IR = 4'h4, ST_UPD_DR = 4'h5, ST_CAP_DR = 4'h6, ST_SEL_DR = 4'h7,
    ST_EX2_IR = 4'h8, ST_EX1_IR = 4'h9, ST_SH_IR = 4'hA, ST_PA_IR = 4'hB,
    ST_IDLE = 4'hC, ST_UPD_IR = 4'hD, ST_CAP_IR = 4'hE, ST_RESET = 4'hF
  } tap_state_t;
endpackage

// [rtl/tap_link_if.sv]
/*
  Signals shared between the port core, its state machine and its boundary
  register. Assumes all three sit on the one system clock.
*/
interface tap_link_if;
  import tap_pkg::*;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic soft_rst;
  tap_state_t state;
  logic [IR_W-1:0] ir;
  logic [BSR_W-1:0] pin_snap;
  logic bsr_so;
  logic [BSR_W-1:0] bsr_upd;
  modport core (output tck_rise, tck_fall, tms, tdi, soft_rst, ir, pin_snap,
                input state, bsr_so, bsr_upd);
  modport fsm (input tck_rise, tms, soft_rst, output state);
  modport bsr (input tck_rise, tck_fall, tdi, state, ir, pin_snap,
               output bsr_so, bsr_upd);
endinterface

// [rtl/tap_fsm.sv]
/*
  Sixteen-state test port controller, stepped by the detected rising test
  clock edge. Assumes tms is already synchronised to clk.
*/
module tap_fsm
  import tap_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  tap_link_if.fsm lnk
);
  tap_state_t state_r;
  tap_state_t state_nxt;
  logic t;

  // next state from the sampled tms level
  always_comb begin
    t = lnk.tms;
    state_nxt = state_r;
    case (state_r)
      ST_RESET: state_nxt = t ? ST_RESET : ST_IDLE;
      ST_IDLE: state_nxt = t ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = t ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = t ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_nxt = t ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = t ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_nxt = t ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_nxt = t ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = t ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = t ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_nxt = t ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_nxt = t ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = t ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_nxt = t ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_nxt = t ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = t ? ST_SEL_DR : ST_IDLE;
      default: state_nxt = ST_RESET;
    endcase
  end

  // state advances only on a rising test clock edge
  always_ff @(posedge clk) begin
    if (sys_rst || lnk.soft_rst) begin
      state_r <= ST_RESET;
    end else if (lnk.tck_rise) begin
      state_r <= state_nxt;
    end
  end

  assign lnk.state = state_r;

  property p_idle_step;
    @(posedge clk) disable iff (sys_rst || lnk.soft_rst)
      lnk.tck_rise && state_r == ST_IDLE && lnk.tms |=> state_r == ST_SEL_DR;
  endproperty
  a_idle_step: assert property (p_idle_step)
    else $error("idle with tms high did not go to select-dr");

  property p_hold_state;
    @(posedge clk) disable iff (sys_rst)
      !lnk.tck_rise && !lnk.soft_rst |=> $stable(state_r);
  endproperty
  a_hold_state: assert property (p_hold_state)
    else $error("state moved without a rising test clock edge");
endmodule

// [rtl/tap_bsr.sv]
/*
  Boundary scan register: capture stage, shift path and latched update stage
  whose top cell gates the output bus. Assumes the controller state and
  instruction arrive on the same clock.
*/
module tap_bsr
  import tap_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  tap_link_if.bsr lnk
);
  logic [BSR_W-1:0] sr_r;
  logic [BSR_W-1:0] upd_r;

  // which instructions put the chain in the path or may latch it
  wire sel = lnk.ir == INS_EXT_TEST || lnk.ir == INS_SAMPLE_Z || lnk.ir == INS_SAMPLE;
  wire upd_ok = lnk.ir == INS_EXT_TEST || lnk.ir == INS_SAMPLE;
  wire cap_en = lnk.tck_rise && lnk.state == ST_CAP_DR && sel;
  wire sh_en = lnk.tck_rise && lnk.state == ST_SH_DR && sel;
  wire upd_en = lnk.tck_fall && lnk.state == ST_UPD_DR && upd_ok;

  // capture of pin snapshot, then shift toward the low end
  always_ff @(posedge clk) begin
    if (cap_en) begin
      sr_r <= lnk.pin_snap;
    end else if (sh_en) begin
      sr_r <= {lnk.tdi, sr_r[BSR_W-1:1]};
    end
  end

  // update stage, preset in reset and test-logic-reset
  always_ff @(posedge clk) begin
    if (sys_rst || lnk.state == ST_RESET) begin
      upd_r <= BSR_UPD_RST;
    end else if (upd_en) begin
      upd_r <= sr_r;
    end
  end

  assign lnk.bsr_so = sr_r[0];
  assign lnk.bsr_upd = upd_r;

  property p_capture;
    @(posedge clk) disable iff (sys_rst) cap_en |=> sr_r == $past(lnk.pin_snap);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture-dr did not load the pin snapshot");

  property p_preload;
    @(posedge clk) disable iff (sys_rst) upd_en |=> upd_r == $past(sr_r);
  endproperty
  a_preload: assert property (p_preload)
    else $error("update-dr did not latch the shifted pattern");

  property p_oe_preset;
    @(posedge clk) disable iff (sys_rst)
      lnk.state == ST_RESET |=> upd_r[OE_CELL] ##1 upd_r[OE_CELL];
  endproperty
  a_oe_preset: assert property (p_oe_preset)
    else $error("output-enable cell not preset high in reset state");
endmodule

// [rtl/tap_port.sv]
/*
  Boundary-scan test access port of a synchronous memory: pin synchronisers,
  instruction register, identification and bypass registers, output bus
  control, and an Avalon-MM slave with waitrequest for status and control.
  Assumes tck, tms, tdi and the pin ring come from outside the clk domain and
  that tck is far slower than clk.
*/
// The Avalon-MM register port and the address map were chosen for this implementation.
module tap_port
  import tap_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = ID_CODE_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_W-1:0] ring_in,
  input wire logic core_q_oe,
  output logic q_bus_oe,
  output logic [BSR_W-2:0] ring_drive,
  output logic extest_on,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  tap_link_if lnk();

  logic [1:0] tck_sync_r;
  logic [1:0] tms_sync_r;
  logic [1:0] tdi_sync_r;
  logic tck_prev_r;
  logic [BSR_W-1:0] ring_s1_r;
  logic [BSR_W-1:0] ring_s2_r;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_sr_r;
  logic [ID_W-1:0] id_sr_r;
  logic byp_r;
  logic tdo_r;
  logic tdo_oe_r;
  logic q_oe_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic soft_rst_r;
  logic [2:0] tms_hi_cnt_r;

  // two-stage synchronisers for the test pins and the pin ring
  always_ff @(posedge clk) begin
    tck_sync_r <= {tck_sync_r[0], tck};
    tms_sync_r <= {tms_sync_r[0], tms};
    tdi_sync_r <= {tdi_sync_r[0], tdi};
    ring_s1_r <= ring_in;
    ring_s2_r <= ring_s1_r;
  end

  // edge memory of the synchronised test clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= tck_sync_r[1];
    end
  end

  // test clock edges and sampled inputs
  wire tck_rise = tck_sync_r[1] && !tck_prev_r;
  wire tck_fall = !tck_sync_r[1] && tck_prev_r;
  wire tms_s = tms_sync_r[1];
  wire tdi_s = tdi_sync_r[1];
  tap_state_t st;

  assign lnk.tck_rise = tck_rise;
  assign lnk.tck_fall = tck_fall;
  assign lnk.tms = tms_s;
  assign lnk.tdi = tdi_s;
  assign lnk.soft_rst = soft_rst_r;
  assign lnk.ir = ir_r;
  assign lnk.pin_snap = ring_s2_r;
  assign st = lnk.state;

  tap_fsm u_fsm (
    .clk(clk),
    .sys_rst(sys_rst),
    .lnk(lnk.fsm)
  );

  tap_bsr u_bsr (
    .clk(clk),
    .sys_rst(sys_rst),
    .lnk(lnk.bsr)
  );

  // instruction decode; reserved codes fall back to the bypass path
  wire is_ext = ir_r == INS_EXT_TEST;
  wire is_id = ir_r == INS_IDENT;
  wire is_hz = ir_r == INS_SAMPLE_Z;
  wire is_smp = ir_r == INS_SAMPLE;
  wire use_bsr = is_ext || is_hz || is_smp;
  wire rise_cap_ir = tck_rise && st == ST_CAP_IR;
  wire rise_sh_ir = tck_rise && st == ST_SH_IR;
  wire fall_upd_ir = tck_fall && st == ST_UPD_IR;
  wire rise_cap_dr = tck_rise && st == ST_CAP_DR;
  wire rise_sh_dr = tck_rise && st == ST_SH_DR;

  // instruction shift stage and current instruction
  always_ff @(posedge clk) begin
    if (sys_rst || st == ST_RESET) begin
      ir_r <= INS_IDENT;
      ir_sr_r <= INS_IDENT;
    end else if (rise_cap_ir) begin
      ir_sr_r <= {1'b0, IR_CAPT_PAT};
    end else if (rise_sh_ir) begin
      ir_sr_r <= {tdi_s, ir_sr_r[IR_W-1:1]};
    end else if (fall_upd_ir) begin
      ir_r <= ir_sr_r;
    end
  end

  // identification and bypass data registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_sr_r <= ID_VALUE;
      byp_r <= 1'b0;
    end else if (rise_cap_dr) begin
      id_sr_r <= ID_VALUE;
      byp_r <= 1'b0;
    end else if (rise_sh_dr) begin
      id_sr_r <= {tdi_s, id_sr_r[ID_W-1:1]};
      byp_r <= tdi_s;
    end
  end

  // serial output source for the current state and instruction
  wire tdo_nxt = (st == ST_SH_IR) ? ir_sr_r[0] :
                 use_bsr ? lnk.bsr_so :
                 is_id ? id_sr_r[0] : byp_r;
  wire tdo_oe_nxt = st == ST_SH_IR || st == ST_SH_DR;

  // tdo and its enable change only on the falling test clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  // output bus enable: float under sample-z, enable cell under external test
  wire q_oe_nxt = is_hz ? 1'b0 : is_ext ? lnk.bsr_upd[OE_CELL] : core_q_oe;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_oe_r <= 1'b0;
    end else begin
      q_oe_r <= q_oe_nxt;
    end
  end

  // consecutive high tms edges, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tms_hi_cnt_r <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        tms_hi_cnt_r <= 3'h0;
      end else if (tms_hi_cnt_r != TMS_RST_EDGES) begin
        tms_hi_cnt_r <= 3'(tms_hi_cnt_r + 3'h1);
      end
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;
  assign q_bus_oe = q_oe_r;
  assign ring_drive = lnk.bsr_upd[BSR_W-2:0];
  assign extest_on = is_ext;

  // bus slave: one wait cycle per access
  wire req = avs_read || avs_write;
  wire sel_status = avs_address == REG_STATUS;
  wire sel_ctrl = avs_address == REG_CTRL;
  wire sel_idread = avs_address == REG_IDREAD;
  wire [31:0] status_word = {22'h0, is_ext, is_hz, lnk.bsr_upd[OE_CELL], ir_r, 4'(st)};
  wire [31:0] rd_mux = sel_status ? status_word : sel_idread ? ID_VALUE : 32'h0;
  wire wr_rst = avs_write && ack_r && sel_ctrl && avs_writedata[CTRL_RST_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      soft_rst_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
      soft_rst_r <= wr_rst;
      if (avs_read && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = req && !ack_r;
  assign avs_readdata = rdata_r;

  property p_ir_capture;
    @(posedge clk) disable iff (sys_rst) rise_cap_ir |=> ir_sr_r[1:0] == IR_CAPT_PAT;
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("capture-ir did not load the 01 pattern");

  property p_ir_update;
    @(posedge clk) disable iff (sys_rst) fall_upd_ir |=> ir_r == $past(ir_sr_r);
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("update-ir did not make the shifted code current");

  property p_ir_hold;
    @(posedge clk) disable iff (sys_rst)
      !fall_upd_ir && st != ST_RESET |=> $stable(ir_r);
  endproperty
  a_ir_hold: assert property (p_ir_hold)
    else $error("instruction changed outside update-ir");

  property p_reset_ident;
    @(posedge clk) disable iff (sys_rst) st == ST_RESET |=> ir_r == INS_IDENT;
  endproperty
  a_reset_ident: assert property (p_reset_ident)
    else $error("test-logic-reset did not select identification");

  property p_id_load;
    @(posedge clk) disable iff (sys_rst) rise_cap_dr |=> id_sr_r == ID_VALUE;
  endproperty
  a_id_load: assert property (p_id_load)
    else $error("capture-dr did not load the identification code");

  property p_bypass_shift;
    @(posedge clk) disable iff (sys_rst) rise_sh_dr |=> byp_r == $past(tdi_s);
  endproperty
  a_bypass_shift: assert property (p_bypass_shift)
    else $error("bypass cell did not take tdi");

  property p_highz;
    @(posedge clk) disable iff (sys_rst) is_hz ##1 is_hz |-> !q_oe_r;
  endproperty
  a_highz: assert property (p_highz)
    else $error("output bus driven under sample-z");

  property p_extest_oe;
    @(posedge clk) disable iff (sys_rst)
      is_ext |=> q_oe_r == $past(lnk.bsr_upd[OE_CELL]);
  endproperty
  a_extest_oe: assert property (p_extest_oe)
    else $error("output bus enable does not follow the enable cell");

  property p_tdo_fall;
    @(posedge clk) disable iff (sys_rst) !tck_fall |=> $stable(tdo_r) && $stable(tdo_oe_r);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo changed away from a falling test clock edge");

  property p_five_tms;
    @(posedge clk) disable iff (sys_rst) tms_hi_cnt_r == TMS_RST_EDGES |-> st == ST_RESET;
  endproperty
  a_five_tms: assert property (p_five_tms)
    else $error("five high tms edges did not reach test-logic-reset");
endmodule

// [verif/jtag_host_model.sv]
/*
  Behavioural board-level test controller: makes the test clock, drives tms and
  tdi, samples tdo. Assumes the caller enters each task at a rising clk edge.
*/
module jtag_host_model (
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 20; // 160 ns test clock from a 4 ns clk

  // test clock stands low between frames, pulled-up levels on tms and tdi
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one test clock period: data set at the fall, tdo taken before the rise;
  // an undriven tdo reads as the inverse of its level, so a dead enable shows
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (HALF) @(posedge clk);
    o = tdo_oe ? tdo : ~tdo;
    tck <= 1'b1;
    repeat (HALF) @(posedge clk);
    tck <= 1'b0;
  endtask

  // five high tms edges, then park in run-test/idle
  task automatic go_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  // idle -> shift-ir -> update-ir -> idle; only implemented codes are passed
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic o;
    int i;
    step(1'b1, 1'b1, o);
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (i = 0; i < 3; i++) begin
      step(i == 2, code[i], o);
      cap[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask

  // idle -> capture-dr -> n shifts -> update-dr -> idle
  task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic o;
    int i;
    dout = '0;
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

// [verif/tap_port_tb_top.sv]
/*
  Self-checking bench of the test access port: scans through the host model,
  status over the bus. Assumes the model and design share clk.
*/
module tap_port_tb_top
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, tck, tms, tdi, tdo, tdo_oe, core_q_oe, q_bus_oe, extest_on;
  logic avs_read, avs_write, avs_waitrequest;
  logic [BSR_W-1:0] ring_in;
  logic [BSR_W-2:0] ring_drive;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [127:0] exp_q[$], obs_q[$];
  int failures = 0;
  int samples_checked = 0;

  tap_port uut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_in(ring_in), .core_q_oe(core_q_oe), .q_bus_oe(q_bus_oe),
    .ring_drive(ring_drive), .extest_on(extest_on), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  jtag_host_model host (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi));

  // system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic note(input logic [127:0] e, input logic [127:0] o);
    exp_q.push_back(e);
    obs_q.push_back(o);
  endtask

  task automatic check_val(input logic [127:0] e, input logic [127:0] o);
    samples_checked++;
    if (o !== e) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, o, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] st_exp(input logic [2:0] ir, input logic oe,
                                         input logic [3:0] s);
    st_exp = {22'h0, ir == INS_EXT_TEST, ir == INS_SAMPLE_Z, oe, ir, s};
  endfunction

  // bus read: hold the request until waitrequest is seen low
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // monitor: pairs each observed result with the oldest expectation
  initial begin
    forever begin
      @(posedge clk);
      while (obs_q.size() > 0) check_val(exp_q.pop_front(), obs_q.pop_front());
    end
  end

  // watchdog well beyond the expected run of about 76 us
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    logic [127:0] d, pat;
    logic [31:0] w;
    logic [2:0] cap;
    logic [2:0] codes[5];
    int i;
    codes = '{INS_IDENT, INS_BYPASS, INS_SAMPLE_Z, INS_SAMPLE, INS_EXT_TEST};
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    core_q_oe = 1'b0;
    ring_in = '0;
    void'($urandom(52948));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    note(core_q_oe, q_bus_oe);
    note(1'b0, tdo_oe);
    bus_rd(REG_STATUS, w);
    note(32'h0000_009F, w);
    bus_rd(REG_IDREAD, w);
    note(ID_CODE_DEF, w);
    bus_rd(4'hC, w);
    note(32'h0, w);
    $display("reset state test done");
    core_q_oe <= 1'b1;
    host.go_reset();
    host.scan_dr(32, 128'({$urandom, $urandom}), d);
    note(ID_CODE_DEF, d[31:0]);
    note(1'b0, tdo_oe);
    $display("identification scan test done");
    for (i = 0; i < 5; i++) begin
      host.load_ir(codes[i], cap);
      note(3'h1, cap);
      bus_rd(REG_STATUS, w);
      note(st_exp(codes[i], 1'b1, 4'hC), w);
      note(codes[i] != INS_SAMPLE_Z, q_bus_oe);
      note(codes[i] == INS_EXT_TEST, extest_on);
      if (codes[i] == INS_BYPASS) begin
        pat = 128'({$urandom, $urandom});
        host.scan_dr(9, pat, d);
        note({pat[7:0], 1'b0}, d[8:0]);
      end
    end
    $display("instruction set test done");
    ring_in <= BSR_W'({$urandom, $urandom, $urandom, $urandom});
    host.load_ir(INS_SAMPLE, cap);
    pat = {$urandom, $urandom, $urandom, $urandom};
    pat[OE_CELL] = 1'b0;
    host.scan_dr(BSR_W, pat, d);
    note(ring_in, d[BSR_W-1:0]);
    note(pat[BSR_W-2:0], ring_drive);
    note(1'b1, q_bus_oe);
    bus_rd(REG_STATUS, w);
    note(st_exp(INS_SAMPLE, 1'b0, 4'hC), w);
    host.load_ir(INS_EXT_TEST, cap);
    note(1'b0, q_bus_oe);
    note(pat[BSR_W-2:0], ring_drive);
    for (i = 1; i >= 0; i--) begin
      pat[OE_CELL] = i[0];
      host.scan_dr(BSR_W, pat, d);
      note(i[0], q_bus_oe);
    end
    $display("preload and external test done");
    host.go_reset();
    bus_rd(REG_STATUS, w);
    note(32'h0000_009C, w);
    note(1'b1, q_bus_oe);
    host.load_ir(INS_BYPASS, cap);
    bus_wr(REG_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clk);
    bus_rd(REG_STATUS, w);
    note(32'h0000_009F, w);
    $display("return to reset test done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
